// ---- rtl/watchdog_pkg.sv ----
package watchdog_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] CTRL_INDEX = 8'h33;
   localparam logic [7:0] CTRL_ADDR  = {CTRL_INDEX[5:0], 2'b00};
   localparam logic [7:0] CTRL_RESET = 8'h7F;
   localparam int         ACT_BIT    = 7;
   localparam int         MSB_BIT    = 6;
   localparam logic [6:0] ROLL_FROM  = 7'h40;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS    = 100;
   localparam int unsigned PRESCALE_MC      = 16000;
   localparam int unsigned RESET_PULSE_US   = 30;
   localparam int unsigned RESET_PULSE_CYC  = (RESET_PULSE_US * 1000) / CLK_PERIOD_NS;
   localparam int          PRESC_W          = 14;
   localparam int          PULSE_W          = 9;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic       activation_flag;
      logic [6:0] count;
   } control_t;

   typedef struct packed {
      logic hw_watchdog;
      logic halt_reset;
   } options_t;

   typedef enum logic [1:0] {
      ST_RUN   = 2'b01,
      ST_PULSE = 2'b10
   } state_t;

endpackage

// ---- rtl/windowed_watchdog_timer.sv ----
// How it works
// [RQ1] Count steps down every 16000 machine cycles.
// [RQ2] Active and 40h to 3Fh: 30 us reset.
// [RQ3] Counter keeps running while not activated.
// [RQ4] Software refreshes with C0h to FFh.
// [RQ5] Any reset leaves the watchdog deactivated; with hw_watchdog_option set the code keeps it active after reset.
// [RQ6] Activation flag set by software, cleared only by reset.
// [RQ7] Flag set with count MSB clear resets.
// [RQ8] HALT while active resets unless option off.
// [RQ9] Hardware option makes watchdog always active.
// [RQ10] Software refreshes before halt without reset.
// [RQ11] Control resets to 7Fh, flag then count.
// [RQ12] Prescaler phase unknown at refresh time.
// [RQ13] Options sampled at reset; no interrupt.
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ns
module windowed_watchdog_timer
   import watchdog_pkg::*;
#(
   parameter int unsigned PRESCALE_CYCLES = PRESCALE_MC
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        hw_watchdog_option,
   input  wire logic        halt_reset_option,
   input  wire logic        halt_exec,
   output logic             reset_out_n
);

   // ----------------------------------------------------------------
   // Option byte capture
   // ----------------------------------------------------------------
   // The synchroniser stages carry no reset so they already follow the
   // pins while reset is held; the capture then happens on release.
   options_t sync1_q;
   options_t sync2_q;
   options_t opt_q;
   options_t opt_d;
   logic     cap_done_q;
   logic     cap_done_d;

   always_ff @(posedge aclk) begin
      sync1_q <= '{hw_watchdog: hw_watchdog_option, halt_reset: halt_reset_option};
      sync2_q <= sync1_q;
   end

   always_comb begin
      opt_d      = opt_q;
      cap_done_d = 1'b1;
      if (!cap_done_q) begin
         opt_d = sync2_q; // see [RQ13]
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         opt_q      <= '0;
         cap_done_q <= 1'b0;
      end else begin
         opt_q      <= opt_d;
         cap_done_q <= cap_done_d;
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------------------------------
   logic [7:0] aw_addr_q;
   logic [7:0] aw_addr_d;
   logic       aw_full_q;
   logic       aw_full_d;
   logic [7:0] w_data_q;
   logic [7:0] w_data_d;
   logic       w_strb_q;
   logic       w_strb_d;
   logic       w_full_q;
   logic       w_full_d;
   logic       bvalid_q;
   logic       bvalid_d;
   logic [1:0] bresp_q;
   logic [1:0] bresp_d;
   logic       rvalid_q;
   logic       rvalid_d;
   logic [1:0] rresp_q;
   logic [1:0] rresp_d;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic       wr_go;
   logic       wr_hit;
   logic       ctrl_wr;
   control_t   ctrl_q;

   assign s_axi_awready = !aw_full_q && !bvalid_q;
   assign s_axi_wready  = !w_full_q && !bvalid_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rresp   = rresp_q;
   assign s_axi_rdata   = {24'h000000, rdata_q};

   assign wr_go   = aw_full_q && w_full_q && !bvalid_q;
   assign wr_hit  = aw_addr_q[7:2] == CTRL_ADDR[7:2];
   assign ctrl_wr = wr_go && wr_hit && w_strb_q;

   always_comb begin
      aw_addr_d = aw_addr_q;
      aw_full_d = aw_full_q;
      w_data_d  = w_data_q;
      w_strb_d  = w_strb_q;
      w_full_d  = w_full_q;
      bvalid_d  = bvalid_q;
      bresp_d   = bresp_q;
      rvalid_d  = rvalid_q;
      rresp_d   = rresp_q;
      rdata_d   = rdata_q;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_addr_d = s_axi_awaddr;
         aw_full_d = 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_data_d = s_axi_wdata[7:0];
         w_strb_d = s_axi_wstrb[0];
         w_full_d = 1'b1;
      end
      if (wr_go) begin
         aw_full_d = 1'b0;
         w_full_d  = 1'b0;
         bvalid_d  = 1'b1;
         bresp_d   = wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_q && s_axi_bready) begin
         bvalid_d = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_d = 1'b1;
         if (s_axi_araddr[7:2] == CTRL_ADDR[7:2]) begin
            rdata_d = ctrl_q;
            rresp_d = RESP_OKAY;
         end else begin
            rdata_d = 8'h00;
            rresp_d = RESP_SLVERR;
         end
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_d = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_addr_q <= 8'h00;
         aw_full_q <= 1'b0;
         w_data_q  <= 8'h00;
         w_strb_q  <= 1'b0;
         w_full_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= RESP_OKAY;
         rvalid_q  <= 1'b0;
         rresp_q   <= RESP_OKAY;
         rdata_q   <= 8'h00;
      end else begin
         aw_addr_q <= aw_addr_d;
         aw_full_q <= aw_full_d;
         w_data_q  <= w_data_d;
         w_strb_q  <= w_strb_d;
         w_full_q  <= w_full_d;
         bvalid_q  <= bvalid_d;
         bresp_q   <= bresp_d;
         rvalid_q  <= rvalid_d;
         rresp_q   <= rresp_d;
         rdata_q   <= rdata_d;
      end
   end

   // ----------------------------------------------------------------
   // Prescaler and downcounter
   // ----------------------------------------------------------------
   // A refresh does not restart the prescaler, so the first step after
   // a refresh lands anywhere within one prescale period.
   logic [PRESC_W-1:0] presc_q;
   logic [PRESC_W-1:0] presc_d;
   logic               tick;
   control_t           ctrl_d;
   logic               active;
   logic               roll;
   logic               sw_trip;
   logic               halt_trip;

   assign tick   = presc_q == PRESC_W'(PRESCALE_CYCLES - 1);
   assign active = ctrl_q.activation_flag || opt_q.hw_watchdog; // see [RQ9]

   always_comb begin
      presc_d = tick ? '0 : presc_q + 1'b1; // see [RQ12]
      ctrl_d  = ctrl_q;
      if (ctrl_wr) begin
         ctrl_d.activation_flag = ctrl_q.activation_flag | w_data_q[ACT_BIT]; // see [RQ6]
         ctrl_d.count           = w_data_q[6:0];
      end else if (tick) begin
         ctrl_d.count = ctrl_q.count - 7'h01; // see [RQ1] [RQ3]
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         presc_q <= '0;
         ctrl_q  <= CTRL_RESET; // see [RQ5] [RQ11]
      end else begin
         presc_q <= presc_d;
         ctrl_q  <= ctrl_d;
      end
   end

   // ----------------------------------------------------------------
   // Reset generator
   // ----------------------------------------------------------------
   state_t             state_q;
   state_t             state_d;
   logic [PULSE_W-1:0] pulse_cnt_q;
   logic [PULSE_W-1:0] pulse_cnt_d;
   logic               trip;

   // A refresh that leaves the count MSB clear trips at once, which gives software a reset.
   assign roll      = active && tick && !ctrl_wr && ctrl_q.count == ROLL_FROM; // see [RQ2]
   assign sw_trip   = ctrl_wr && !w_data_q[MSB_BIT]
                      && (w_data_q[ACT_BIT] || active); // see [RQ7]
   assign halt_trip = active && halt_exec && opt_q.halt_reset; // see [RQ8]
   assign trip      = roll || sw_trip || halt_trip;
   assign reset_out_n = !state_q[1];

   always_comb begin
      state_d     = state_q;
      pulse_cnt_d = pulse_cnt_q;
      case (state_q)
         ST_RUN: begin
            pulse_cnt_d = '0;
            if (trip) begin
               state_d = ST_PULSE;
            end
         end
         ST_PULSE: begin
            pulse_cnt_d = pulse_cnt_q + 1'b1;
            if (pulse_cnt_q == PULSE_W'(RESET_PULSE_CYC - 1)) begin
               state_d     = ST_RUN; // see [RQ2]
               pulse_cnt_d = '0;
            end
         end
         default: begin
            state_d     = ST_RUN;
            pulse_cnt_d = '0;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q     <= ST_RUN;
         pulse_cnt_q <= '0;
      end else begin
         state_q     <= state_d;
         pulse_cnt_q <= pulse_cnt_d;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence s_step;
      tick && !ctrl_wr;
   endsequence

   sequence s_run_idle;
      state_q == ST_RUN;
   endsequence

   a_prescale_step: assert property (s_step |=> // see [RQ1]
                                     ctrl_q.count == $past(ctrl_q.count) - 7'h01)
      else $error("count did not step on prescaler wrap");

   a_no_step_idle: assert property (!tick && !ctrl_wr |=> $stable(ctrl_q.count)) // see [RQ1]
      else $error("count changed without prescaler wrap");

   a_roll_trip: assert property (s_step ##0 active && ctrl_q.count == ROLL_FROM // see [RQ2]
                                 && state_q == ST_RUN |=> !reset_out_n)
      else $error("rollover while active did not reset");

   a_pulse_length: assert property ($fell(reset_out_n) |-> !reset_out_n[*8] // see [RQ2]
                                    ##0 pulse_cnt_q == PULSE_W'(7))
      else $error("reset pulse count wrong");

   a_pulse_end: assert property ($rose(reset_out_n) |-> // see [RQ2]
                                 $past(pulse_cnt_q) == PULSE_W'(RESET_PULSE_CYC - 1))
      else $error("reset pulse ended at wrong length");

   a_free_running: assert property (s_step ##0 !active && ctrl_q.count == ROLL_FROM // see [RQ3]
                                    && state_q == ST_RUN && !halt_exec
                                    |=> reset_out_n && ctrl_q.count == 7'h3F)
      else $error("inactive rollover misbehaved");

   a_flag_sticky: assert property (ctrl_q.activation_flag |=> ctrl_q.activation_flag) // see [RQ6]
      else $error("activation flag cleared");

   a_sw_reset: assert property (s_run_idle ##0 ctrl_wr && w_data_q[ACT_BIT] // see [RQ7]
                                && !w_data_q[MSB_BIT] |=> !reset_out_n)
      else $error("software reset missing");

   a_halt_reset: assert property (s_run_idle ##0 halt_exec && active // see [RQ8]
                                  |=> reset_out_n == !opt_q.halt_reset)
      else $error("halt reset wrong");

   // With the hardware option the rollover resets whatever the flag holds.
   a_hw_always: assert property (s_step ##0 opt_q.hw_watchdog // see [RQ9]
                                 && ctrl_q.count == ROLL_FROM && state_q == ST_RUN
                                 |=> !reset_out_n)
      else $error("hardware option did not force a reset");

   a_opt_hold: assert property (cap_done_q |=> $stable(opt_q)) // see [RQ13]
      else $error("option settings changed after capture");

   a_reset_value: assert property (!$past(aresetn) |-> // see [RQ5] [RQ11]
                                   ctrl_q == CTRL_RESET && reset_out_n)
      else $error("control not at reset value");

endmodule

// ---- bench/windowed_watchdog_timer_test.sv ----
`timescale 1ns/1ns
module windowed_watchdog_timer_test;
   import watchdog_pkg::*;

   localparam int P = 20;

   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic        hw_opt, halt_opt, halt_exec, reset_out_n;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [7:0]  awaddr, araddr, a, b;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   logic [7:0]  vals[$];
   int          n_mismatch, n_compared, k, low_run, last_run;

   windowed_watchdog_timer #(.PRESCALE_CYCLES(P)) dut_u (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .hw_watchdog_option(hw_opt),
      .halt_reset_option(halt_opt), .halt_exec(halt_exec), .reset_out_n(reset_out_n)
   );

   // ----------------------------------------------------------------
   // Checking and bus tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic complete_run;
      $display("Comparisons %0d, mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // Ready is sampled at the falling edge, so it is the value seen by the next rising edge.
   task automatic wr(input logic [7:0] ad, input logic [7:0] d, input logic [3:0] s,
                     input logic [1:0] er);
      logic       ta, tw, tb;
      logic [1:0] r;
      @(posedge aclk);
      awaddr <= ad;
      wdata <= {24'h000000, d};
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(negedge aclk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         tb = bvalid;
         r = bresp;
         @(posedge aclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tb) break;
      end
      bready <= 1'b0;
      chk(r, er);
   endtask

   task automatic rd(input logic [7:0] ad, output logic [7:0] d, input logic [1:0] er);
      logic        ta, tb;
      logic [1:0]  r;
      logic [31:0] q;
      @(posedge aclk);
      araddr <= ad;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(negedge aclk);
         ta = arvalid && arready;
         tb = rvalid;
         r = rresp;
         q = rdata;
         @(posedge aclk);
         if (ta) arvalid <= 1'b0;
         if (tb) break;
      end
      rready <= 1'b0;
      chk(r, er);
      chk(q[31:8], 24'h000000);
      d = q[7:0];
   endtask

   task automatic rst(input logic hw, input logic hr);
      @(posedge aclk);
      aresetn <= 1'b0;
      hw_opt <= hw;
      halt_opt <= hr;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
   endtask

   task automatic halt;
      @(posedge aclk);
      halt_exec <= 1'b1;
      @(posedge aclk);
      halt_exec <= 1'b0;
   endtask

   // Length of each low stretch of the reset request, in cycles.
   always @(negedge aclk) begin
      if (reset_out_n === 1'b0) begin
         low_run <= low_run + 1;
      end else begin
         if (low_run != 0) last_run <= low_run;
         low_run <= 0;
      end
   end

   // The fall must come no earlier than lo and before hi cycles; the low time is fixed.
   task automatic pulse(input int lo, input int hi);
      int t, n;
      for (t = 0; t < hi && low_run == 0; t++) @(negedge aclk);
      chk({t >= lo, low_run != 0}, 2'b11);
      for (n = 0; n < 400 && low_run != 0; n++) @(negedge aclk);
      chk((n < 400) ? last_run : 0, RESET_PULSE_CYC);
   endtask

   task automatic quiet(input int c);
      logic seen;
      seen = 1'b0;
      repeat (c) begin
         @(negedge aclk);
         if (reset_out_n !== 1'b1) seen = 1'b1;
      end
      chk(seen, 1'b0);
   endtask

   // ----------------------------------------------------------------
   // Stimulus
   // ----------------------------------------------------------------
   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end

   initial begin
      #(100 * 60000);
      n_mismatch++;
      complete_run();
   end

   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, halt_exec} = '0;
      {hw_opt, halt_opt, awaddr, araddr, wdata, wstrb} = '0;
      void'($urandom(19241));
      rst(1'b0, 1'b0);
      rd(CTRL_ADDR, a, RESP_OKAY);
      chk(a, 8'h7F);
      repeat (3 * P) @(posedge aclk);
      rd(CTRL_ADDR, b, RESP_OKAY);
      chk(((a - b) & 8'h7F) inside {8'h03, 8'h04}, 1'b1);
      wr(CTRL_ADDR, 8'h80, 4'h0, RESP_OKAY);
      wr(8'h10, 8'hFF, 4'hF, RESP_SLVERR);
      rd(8'h10, a, RESP_SLVERR);
      chk(a, 8'h00);
      rd(CTRL_ADDR, a, RESP_OKAY);
      chk(a[7], 1'b0);
      wr(CTRL_ADDR, 8'hFF, 4'hF, RESP_OKAY);
      wr(CTRL_ADDR, 8'h7F, 4'hF, RESP_OKAY);
      rd(CTRL_ADDR, a, RESP_OKAY);
      chk({a[7], a[6:0] inside {7'h7F, 7'h7E}}, 2'b11);
      quiet(20);
      rst(1'b0, 1'b0);
      quiet(64 * P + 10);
      rd(CTRL_ADDR, a, RESP_OKAY);
      chk(a, 8'h3F);
      rst(1'b0, 1'b0);
      wr(CTRL_ADDR, 8'hBF, 4'hF, RESP_OKAY);
      pulse(0, 6);
      rst(1'b0, 1'b1);
      halt();
      quiet(20);
      wr(CTRL_ADDR, 8'hFF, 4'hF, RESP_OKAY);
      halt();
      pulse(0, 5);
      rst(1'b0, 1'b0);
      wr(CTRL_ADDR, 8'hFF, 4'hF, RESP_OKAY);
      halt();
      quiet(20);
      rst(1'b1, 1'b0);
      pulse(63 * P, 64 * P + 6);
      vals = {8'hC0, 8'hFF};
      repeat (3) vals.push_back(8'hC0 | 8'($urandom % 64));
      foreach (vals[i]) begin
         rst(1'b0, 1'b0);
         wr(CTRL_ADDR, vals[i], 4'hF, RESP_OKAY);
         k = int'(vals[i][5:0]);
         pulse(k * P - 3, (k + 1) * P + 4);
      end
      complete_run();
   end
endmodule
